//--- hw/htcd_decoder.sv
// Host transport command decoder: frame parsing, paging and option bits
//
// Contract
// - Frame is command word then payload words
// - Address is 8-bit page plus 7-bit offset
// - Paged and stream-start accesses use page register
// - Bit15 clear: paged offset, length+1 words
// - Address increments after each word
// - Offsets 0-119 with bit15: direct page access
// - Direction bit: 0 read, 1 write
// - Start paged: offset 0, length+1 words
// - Continue paged: resume at saved pointer
// - Upper byte 0xfe loads page register
// - Upper byte 0xfd loads option bits
// - All-ones word is a no-op
// - Option bit4 selects interrupt drive mode
// - Option bit3 selects stall drive mode
// - Option bit2 enables stall output
// - Option bit1 sets stall active level
// - Option bit0 sets payload byte order
// - Page 255 reserved for code loading
// - Back-to-back words at 10 MHz
// - Straps select parallel or serial port
`timescale 1ns/1ps
`include "htcd_defines.svh"

module htcd_decoder
    import htcd_pkg::*;
#(
    parameter int PAGE_W = `HTCD_PAGE_W,
    parameter int OFS_W  = `HTCD_OFS_W
) (
    input  wire logic          clock,
    input  wire logic          rst,
    input  wire logic [2:0]    port_strap_inputs,
    input  wire htcd_word_t    par_word,
    input  wire htcd_word_t    ser_word,
    input  wire logic          host_read_take,
    input  wire logic          parallel_chip_select_n,
    input  wire logic          stall_request,
    input  wire logic          irq_request,
    input  wire logic          mem_ack,
    input  wire logic [15:0]   mem_rdata,
    output htcd_mem_req_t      mem_req,
    output htcd_word_t         host_rdata,
    output logic               word_ready,
    output logic               serial_selected,
    output logic               code_load,
    output logic               little_endian,
    output logic [7:0]         page_select,
    output logic [7:0]         pin_option_config,
    output logic               host_stall_line_o,
    output logic               host_stall_line_oe_n,
    output logic               irq_o,
    output logic               irq_oe_n
);

    // ------------------------------------------------------------
    // Constants
    // ------------------------------------------------------------
    // Words take at least this many clocks at the highest host rate
    localparam int WORD_CYC = `HTCD_CLK_MHZ / `HTCD_WORD_RATE_MHZ;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    htcd_state_t        state_q,   state_d;
    logic [7:0]         page_q,    page_d;
    logic [7:0]         opt_q,     opt_d;
    logic [PAGE_W-1:0]  xpage_q,   xpage_d;
    logic [OFS_W-1:0]   ofs_q,     ofs_d;
    logic [8:0]         left_q,    left_d;
    logic               wr_q,      wr_d;
    logic               direct_q,  direct_d;
    logic               stream_q,  stream_d;
    logic [7:0]         cont_pg_q, cont_pg_d;
    logic [OFS_W-1:0]   cont_of_q, cont_of_d;
    logic               cont_wrap_q, cont_wrap_d;
    htcd_mem_req_t      req_q,     req_d;
    htcd_word_t         rd_q,      rd_d;
    logic               serial_q,  serial_d;
    logic               so_q,      so_d;
    logic               soe_n_q,   soe_n_d;
    logic               io_q,      io_d;
    logic               ioe_n_q,   ioe_n_d;
    logic               rdy_q,     rdy_d;
    logic               code_q,    code_d;
    htcd_word_t         in_w;
    logic [15:0]        cmd;
    logic [15:0]        swapped;
    logic               stall_act;

    // ------------------------------------------------------------
    // Port selection and input word
    // ------------------------------------------------------------
    always_comb begin
        serial_d = (port_strap_inputs == `HTCD_PORT_SERIAL);
        in_w     = serial_q ? ser_word : par_word;
        cmd      = in_w.data;
        swapped  = opt_q[`HTCD_OPT_ENDIAN] ? {in_w.data[7:0], in_w.data[15:8]} : in_w.data;
    end

    // ------------------------------------------------------------
    // Frame decoder
    // ------------------------------------------------------------
    always_comb begin
        state_d     = state_q;
        page_d      = page_q;
        opt_d       = opt_q;
        xpage_d     = xpage_q;
        ofs_d       = ofs_q;
        left_d      = left_q;
        wr_d        = wr_q;
        direct_d    = direct_q;
        stream_d    = stream_q;
        cont_pg_d   = cont_pg_q;
        cont_of_d   = cont_of_q;
        cont_wrap_d = cont_wrap_q;
        req_d       = req_q;
        rd_d        = rd_q;
        rd_d.valid  = 1'b0;
        rdy_d       = 1'b0;
        case (state_q)
            HTCD_IDLE: begin
                rdy_d = 1'b1;
                // Only a word offered while ready was shown is taken
                if (in_w.valid && rdy_q) begin
                    wr_d = cmd[`HTCD_CMD_DIR_BIT];
                    if (!cmd[`HTCD_CMD_PAGED_BIT]) begin
                        xpage_d  = page_q;
                        ofs_d    = cmd[14:8];
                        left_d   = {2'b00, cmd[6:0]};
                        direct_d = 1'b0;
                        stream_d = 1'b0;
                        state_d  = HTCD_XFER;
                    end else if (cmd[14:8] <= `HTCD_DIRECT_OFS_MAX) begin
                        xpage_d  = '0;
                        ofs_d    = cmd[14:8];
                        left_d   = {2'b00, cmd[6:0]};
                        direct_d = 1'b1;
                        stream_d = 1'b0;
                        state_d  = HTCD_XFER;
                    end else if (cmd == `HTCD_CMD_NOP) begin
                        state_d = HTCD_IDLE;
                    end else if (cmd[15:11] == `HTCD_STREAM_UPPER && cmd[10] == 1'b0) begin
                        wr_d     = cmd[8];
                        direct_d = 1'b0;
                        stream_d = 1'b1;
                        left_d   = {1'b0, cmd[7:0]};
                        state_d  = HTCD_XFER;
                        if (!cmd[9]) begin
                            // Start at offset 0 of selected page
                            xpage_d = page_q;
                            ofs_d   = '0;
                        end else begin
                            xpage_d = cont_pg_q;
                            ofs_d   = cont_of_q;
                        end
                    end else if (cmd[15:8] == `HTCD_UPPER_PAGE) begin
                        page_d = cmd[7:0];
                    end else if (cmd[15:8] == `HTCD_UPPER_CONFIG) begin
                        opt_d = cmd[7:0];
                    end
                end
                // Drop ready at once so no word slips in before the transfer
                if (state_d != HTCD_IDLE) begin
                    rdy_d = 1'b0;
                end
            end
            HTCD_XFER: begin
                // Write waits for its payload word, read issues at once
                rdy_d = wr_q;
                if (!wr_q || (in_w.valid && rdy_q)) begin
                    req_d.req    = 1'b1;
                    req_d.write  = wr_q;
                    req_d.direct = direct_q;
                    req_d.page   = xpage_q;
                    req_d.offset = ofs_q;
                    req_d.wdata  = swapped;
                    rdy_d        = 1'b0;
                    state_d      = HTCD_WAIT;
                end
            end
            HTCD_WAIT: begin
                if (mem_ack) begin
                    req_d.req = 1'b0;
                    if (!req_q.write) begin
                        rd_d.valid = 1'b1;
                        rd_d.data  = opt_q[`HTCD_OPT_ENDIAN]
                                   ? {mem_rdata[7:0], mem_rdata[15:8]} : mem_rdata;
                    end
                    ofs_d = ofs_q + 7'h01;
                    if (stream_q && ofs_q == '1) begin
                        // Long streams roll into the next page
                        xpage_d = xpage_q + 8'h01;
                    end
                    if (stream_q) begin
                        cont_pg_d   = (ofs_q == '1) ? xpage_q + 8'h01 : xpage_q;
                        cont_of_d   = ofs_q + 7'h01;
                        cont_wrap_d = (ofs_q == '1);
                    end
                    if (left_q == '0) begin
                        state_d = HTCD_IDLE;
                    end else begin
                        left_d  = left_q - 9'h001;
                        state_d = HTCD_XFER;
                    end
                end
            end
            default: state_d = HTCD_IDLE;
        endcase
        // Read valid holds until the host takes the word, but the next read still issues: no overrun buffer
        if (rd_q.valid && !host_read_take) begin
            rd_d.valid = 1'b1;
        end
        // Flag accesses into the code page
        code_d = req_d.req && !req_d.direct && (req_d.page == `HTCD_CODE_PAGE);
    end

    // ------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------
    always_comb begin
        stall_act = stall_request && opt_q[`HTCD_OPT_STALL_EN];
        so_d    = stall_act ? opt_q[`HTCD_OPT_STALL_POL] : ~opt_q[`HTCD_OPT_STALL_POL];
        soe_n_d = 1'b0;
        if (!opt_q[`HTCD_OPT_STALL_EN]) begin
            soe_n_d = 1'b1;
        end else if (opt_q[`HTCD_OPT_STALL_DRV]) begin
            soe_n_d = parallel_chip_select_n || !stall_act;
        end else if (parallel_chip_select_n) begin
            so_d = ~opt_q[`HTCD_OPT_STALL_POL];
        end
        if (opt_q[`HTCD_OPT_IRQ_DRV]) begin
            io_d    = irq_request;
            ioe_n_d = 1'b0;
        end else begin
            io_d    = 1'b0;
            ioe_n_d = !irq_request;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            // Clear page, options and partial frame
            state_q     <= HTCD_IDLE;
            page_q      <= `HTCD_PAGE_RST;
            opt_q       <= `HTCD_OPT_RST;
            xpage_q     <= '0;
            ofs_q       <= '0;
            left_q      <= '0;
            wr_q        <= 1'b0;
            direct_q    <= 1'b0;
            stream_q    <= 1'b0;
            cont_pg_q   <= '0;
            cont_of_q   <= '0;
            cont_wrap_q <= 1'b0;
            req_q       <= '0;
            rd_q        <= '0;
            serial_q    <= 1'b0;
            so_q        <= 1'b1;
            soe_n_q     <= 1'b1;
            io_q        <= 1'b0;
            ioe_n_q     <= 1'b1;
            rdy_q       <= 1'b0;
            code_q      <= 1'b0;
        end else begin
            state_q     <= state_d;
            page_q      <= page_d;
            opt_q       <= opt_d;
            xpage_q     <= xpage_d;
            ofs_q       <= ofs_d;
            left_q      <= left_d;
            wr_q        <= wr_d;
            direct_q    <= direct_d;
            stream_q    <= stream_d;
            cont_pg_q   <= cont_pg_d;
            cont_of_q   <= cont_of_d;
            cont_wrap_q <= cont_wrap_d;
            req_q       <= req_d;
            rd_q        <= rd_d;
            serial_q    <= serial_d;
            so_q        <= so_d;
            soe_n_q     <= soe_n_d;
            io_q        <= io_d;
            ioe_n_q     <= ioe_n_d;
            rdy_q       <= rdy_d;
            code_q      <= code_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // One write word per four clocks with a next-cycle ack meets the four-clock budget; reads take three
    assign mem_req              = req_q;
    assign host_rdata           = rd_q;
    assign word_ready           = rdy_q;
    assign serial_selected      = serial_q;
    assign code_load            = code_q;
    assign little_endian        = opt_q[`HTCD_OPT_ENDIAN];
    assign page_select          = page_q;
    assign pin_option_config    = opt_q;
    assign host_stall_line_o    = so_q;
    assign host_stall_line_oe_n = soe_n_q;
    assign irq_o                = io_q;
    assign irq_oe_n             = ioe_n_q;

endmodule : htcd_decoder

//--- hw/htcd_defines.svh
// Offsets, field positions, reset values and timing counts for the host transport decoder
`ifndef HTCD_DEFINES_SVH
`define HTCD_DEFINES_SVH

`define HTCD_PAGE_W          8
`define HTCD_OFS_W           7
`define HTCD_WORD_W          16
`define HTCD_DIRECT_OFS_MAX  7'h77
`define HTCD_CODE_PAGE       8'hff
`define HTCD_CMD_PAGED_BIT   15
`define HTCD_CMD_DIR_BIT     7
`define HTCD_STREAM_UPPER    5'h1f
`define HTCD_UPPER_CONFIG    8'hfd
`define HTCD_UPPER_PAGE      8'hfe
`define HTCD_CMD_NOP         16'hffff
`define HTCD_OPT_ENDIAN      0
`define HTCD_OPT_STALL_POL   1
`define HTCD_OPT_STALL_EN    2
`define HTCD_OPT_STALL_DRV   3
`define HTCD_OPT_IRQ_DRV     4
`define HTCD_PAGE_RST        8'h00
`define HTCD_OPT_RST         8'h00
`define HTCD_PORT_SERIAL     3'h4
`define HTCD_WORD_RATE_MHZ   10
`define HTCD_CLK_MHZ         40

`endif

//--- hw/htcd_pkg.sv
// Types for the host transport command decoder
package htcd_pkg;

    typedef enum logic [2:0] {
        HTCD_IDLE = 3'b001,
        HTCD_XFER = 3'b010,
        HTCD_WAIT = 3'b100
    } htcd_state_t;

    typedef struct packed {
        logic        valid;
        logic [15:0] data;
    } htcd_word_t;

    typedef struct packed {
        logic        req;
        logic        write;
        logic        direct;
        logic [7:0]  page;
        logic [6:0]  offset;
        logic [15:0] wdata;
    } htcd_mem_req_t;

endpackage : htcd_pkg

//--- test/htcd_decoder_asserts.sv
// Port-level checks for the host transport decoder
`timescale 1ns/1ps
module htcd_decoder_asserts
    import htcd_pkg::*;
(
    input wire logic           clock,
    input wire logic           rst,
    input wire logic [2:0]     port_strap_inputs,
    input wire htcd_word_t     par_word,
    input wire htcd_word_t     ser_word,
    input wire logic           word_ready,
    input wire logic           host_read_take,
    input wire logic           parallel_chip_select_n,
    input wire logic           stall_request,
    input wire logic           irq_request,
    input wire logic           mem_ack,
    input wire htcd_mem_req_t  mem_req,
    input wire htcd_word_t     host_rdata,
    input wire logic           serial_selected,
    input wire logic           code_load,
    input wire logic [7:0]     page_select,
    input wire logic [7:0]     pin_option_config,
    input wire logic           host_stall_line_o,
    input wire logic           host_stall_line_oe_n,
    input wire logic           irq_oe_n
);
    logic       pcmd;
    logic [7:0] opt;

    default clocking @(posedge clock); endclocking
    default disable iff (rst);

    assign opt  = pin_option_config;
    assign pcmd = word_ready && ((par_word.valid && par_word.data[15:8] == 8'hfe)
                  || (ser_word.valid && ser_word.data[15:8] == 8'hfe));

    sequence s_rd_pending;
        host_rdata.valid && !host_read_take;
    endsequence

    a_page_by_cmd: assert property (
        $changed(page_select) |-> $past(pcmd) || $past(pcmd, 2)
    ) else $error("page register moved without a page command");
    a_rdata_held: assert property (
        s_rd_pending |=> host_rdata.valid
    ) else $error("read word dropped before the host took it");
    a_req_held: assert property (
        mem_req.req && !mem_ack |=> mem_req.req && $stable(mem_req)
    ) else $error("memory request changed before its answer");
    a_code_page: assert property (
        code_load == (mem_req.req && !mem_req.direct && mem_req.page == 8'hff)
    ) else $error("code load flag wrong");
    a_strap_decode: assert property (
        1'b1 |=> serial_selected == ($past(port_strap_inputs) == 3'h4)
    ) else $error("port select does not follow strap");
    a_stall_off: assert property (
        !opt[2] |=> host_stall_line_oe_n
    ) else $error("stall pin driven while disabled");
    a_stall_idle_pp: assert property (
        opt[2] && !opt[3] && parallel_chip_select_n
        |=> !host_stall_line_oe_n && host_stall_line_o == !$past(opt[1])
    ) else $error("stall pin not driven inactive");
    a_stall_idle_od: assert property (
        opt[2] && opt[3] && parallel_chip_select_n |=> host_stall_line_oe_n
    ) else $error("stall pin driven while deselected");
    a_stall_active: assert property (
        opt[2] && !parallel_chip_select_n && stall_request
        |=> !host_stall_line_oe_n && host_stall_line_o == $past(opt[1])
    ) else $error("stall pin not at its active level");
    a_irq_ttl: assert property (
        opt[4] |=> !irq_oe_n
    ) else $error("interrupt pin not driven in logic mode");
    a_irq_od_idle: assert property (
        !opt[4] && !irq_request |=> irq_oe_n
    ) else $error("open-drain interrupt driven while idle");
endmodule : htcd_decoder_asserts

bind htcd_decoder htcd_decoder_asserts u_asserts (.clock, .rst, .port_strap_inputs,
    .par_word, .ser_word, .word_ready, .host_read_take, .parallel_chip_select_n,
    .stall_request, .irq_request, .mem_ack, .mem_req, .host_rdata, .serial_selected,
    .code_load, .page_select, .pin_option_config, .host_stall_line_o,
    .host_stall_line_oe_n, .irq_oe_n);

//--- test/htcd_mem_model.sv
// Internal memory responder for the decoder bus
`timescale 1ns/1ps
module htcd_mem_model
    import htcd_pkg::*;
(
    input  wire logic           clock,
    input  wire logic           rst,
    input  wire logic           slow,
    input  wire htcd_mem_req_t  mem_req,
    output logic                mem_ack,
    output logic [15:0]         mem_rdata
);
    logic [15:0] mem [0:65535];
    logic [1:0]  wait_q;
    logic [15:0] idx;

    assign idx = {mem_req.direct, mem_req.page, mem_req.offset};

    // Read data toggles outside an answer so a stale value is never trusted
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            mem_ack   <= 1'b0;
            wait_q    <= 2'h0;
            mem_rdata <= 16'h0000;
        end else begin
            mem_ack   <= 1'b0;
            mem_rdata <= ~mem_rdata;
            if (mem_req.req && !mem_ack) begin
                if (slow && wait_q != 2'h3) begin
                    wait_q <= wait_q + 2'h1;
                end else begin
                    wait_q    <= 2'h0;
                    mem_ack   <= 1'b1;
                    mem_rdata <= mem[idx];
                    if (mem_req.write) begin
                        mem[idx] <= mem_req.wdata;
                    end
                end
            end
        end
    end
endmodule : htcd_mem_model

//--- test/tb.sv
// Self-checking bench for the host transport decoder
`timescale 1ns/1ps
module tb
    import htcd_pkg::*;
;
    logic clock, rst, use_ser, take, cs_n, stall_req, irq_req, slow;
    logic [2:0] strap;
    logic [7:0] opts [5];
    htcd_word_t w, pw, sw, host_rdata;
    htcd_mem_req_t mem_req;
    logic mem_ack, word_ready, serial_selected, little_endian;
    logic [15:0] mem_rdata;
    logic [7:0] page_select, pin_option_config;
    int n_mismatch, n_tests;

    assign pw = use_ser ? '0 : w;
    assign sw = use_ser ? w : '0;

    htcd_decoder u_dut (.clock, .rst, .port_strap_inputs(strap), .par_word(pw),
        .ser_word(sw), .host_read_take(take), .parallel_chip_select_n(cs_n),
        .stall_request(stall_req), .irq_request(irq_req), .mem_ack, .mem_rdata,
        .mem_req, .host_rdata, .word_ready, .serial_selected, .code_load(),
        .little_endian, .page_select, .pin_option_config, .host_stall_line_o(),
        .host_stall_line_oe_n(), .irq_o(), .irq_oe_n());
    htcd_mem_model u_mem (.clock, .rst, .slow, .mem_req, .mem_ack, .mem_rdata);

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // Word is held until an edge that sees the decoder ready
    task automatic send(input logic [15:0] d);
        int n;
        @(posedge clock);
        #1;
        cs_n = 1'b0;
        w = '{valid: 1'b1, data: d};
        n = 0;
        while (word_ready !== 1'b1 && n < 200) begin
            @(posedge clock);
            #1;
            n++;
        end
        @(posedge clock);
        #1;
        w.valid = 1'b0;
        if (n == 200) n_mismatch++;
    endtask : send

    task automatic rd(input logic [15:0] exp);
        int n;
        n = 0;
        while (host_rdata.valid !== 1'b1 && n < 200) begin
            @(posedge clock);
            #1;
            n++;
        end
        if (n == 200) n_mismatch++;
        chk(host_rdata.data, exp);
        #1;
        take = 1'b1;
        @(posedge clock);
        #1;
        take = 1'b0;
    endtask : rd

    task automatic print_verdict;
        $display("TB: mismatches %0d, checks %0d", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : print_verdict

    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    initial begin
        repeat (20000) @(posedge clock);
        n_mismatch++;
        print_verdict();
    end

    initial begin
        {rst, use_ser, take, stall_req, irq_req, slow} = 6'b100000;
        cs_n = 1'b1;
        strap = 3'h2;
        w = '0;
        opts = '{8'h04, 8'h0e, 8'h12, 8'h16, 8'h01};
        repeat (12) @(posedge clock);
        #1;
        rst = 1'b0;
        chk({8'h00, page_select}, 16'h0000);
        chk({8'h00, pin_option_config}, 16'h0000);
        send(16'hfe12);
        send(16'hffff);
        chk({8'h00, page_select}, 16'h0012);
        // Offset 0x10, write, three words
        send(16'h1082);
        for (int i = 0; i < 3; i++) send(16'ha000 + i[15:0]);
        send(16'hffff);
        for (int i = 0; i < 3; i++) chk(u_mem.mem[{9'h012, 7'h10 + i[6:0]}], 16'ha000 + i[15:0]);
        slow = 1'b1;
        send(16'h1002);
        for (int i = 0; i < 3; i++) rd(16'ha000 + i[15:0]);
        slow = 1'b0;
        // Top direct start offset; 120-127 are reached only by a longer transfer stepping past it
        send(16'hf780);
        send(16'h5a5a);
        send(16'hf700);
        rd(16'h5a5a);
        chk(u_mem.mem[{9'h100, 7'h77}], 16'h5a5a);
        chk({8'h00, page_select}, 16'h0012);
        send(16'hf901);
        send(16'hb000);
        send(16'hb001);
        send(16'hfb00);
        send(16'hb002);
        send(16'hf802);
        for (int i = 0; i < 3; i++) rd(16'hb000 + i[15:0]);
        send(16'hfeff);
        send(16'h0080);
        send(16'hc0de);
        send(16'hfe12);
        // Reserved option bits always written as zero
        foreach (opts[k]) begin
            send({8'hfd, opts[k]});
            send(16'hffff);
            chk({8'h00, pin_option_config}, {8'h00, opts[k]});
            {cs_n, stall_req, irq_req} = 3'b111;
            repeat (3) @(posedge clock);
            #1;
            cs_n = 1'b0;
            repeat (3) @(posedge clock);
            #1;
            {stall_req, irq_req} = 2'b00;
        end
        chk({15'h0, little_endian}, 16'h0001);
        send(16'h1480);
        send(16'h1234);
        send(16'hffff);
        chk(u_mem.mem[{9'h012, 7'h14}], 16'h3412);
        strap = 3'h4;
        use_ser = 1'b1;
        repeat (2) @(posedge clock);
        #1;
        chk({15'h0, serial_selected}, 16'h0001);
        send(16'hfe34);
        send(16'hffff);
        chk({8'h00, page_select}, 16'h0034);
        rst = 1'b1;
        repeat (2) @(posedge clock);
        #1;
        rst = 1'b0;
        chk({page_select, pin_option_config}, 16'h0000);
        print_verdict();
    end
endmodule : tb
